// file: rtl/phy_ext_page_consts.vh
// Register indices, field positions, reset values and codes for the page/SerDes register bank
`ifndef PHY_EXT_PAGE_CONSTS_VH
`define PHY_EXT_PAGE_CONSTS_VH

// Management register indices (byte address is four times the index)
`define IDX_SERDES_MEDIA 5'h10
`define IDX_SERDES_MAC 5'h11
`define IDX_PAGE_SELECT 5'h1f
`define IDX_STD_LAST 5'h0f
`define IDX_EXT_FIRST 5'h10
`define IDX_EXT_LAST 5'h1e

// Block-local registers, selected by haddr bit 7
`define LOC_INT_STATUS 5'h00
`define LOC_INT_ENABLE 5'h01
`define LOC_INT_CLEAR 5'h02

// Page select codes
`define PAGE_MAIN 16'h0000
`define PAGE_EXT 16'h0001
`define PAGE_GPIO 16'h0010
`define PAGE_RESET 16'h0000

// Outside register spaces reached through the forwarding port
`define SPACE_STD 2'h0
`define SPACE_MAIN 2'h1
`define SPACE_GPIO 2'h2

// Media register fields
`define MED_TX_RF_HI 15
`define MED_TX_RF_LO 14
`define MED_LP_RF_HI 13
`define MED_LP_RF_LO 12
`define MED_PAR_DET 11
`define MED_SIG_DET 10
`define MED_ALLOW_1000X 9
`define MED_ALLOW_100FX 8
`define MED_RESTART_REQ 7
`define MED_FAR_FAULT 6
`define MED_WR_MASK 16'hcb00

// MAC/media control fields
`define CTL_MEDIA_EQ 9
`define CTL_MAC_EQ 8
`define CTL_MEDIA_SW_HI 7
`define CTL_MEDIA_SW_LO 5
`define CTL_MAC_SW_HI 4
`define CTL_MAC_SW_LO 2
`define CTL_MAC_HYST 1
`define CTL_MEDIA_HYST 0
`define CTL_WR_MASK 16'h03ff

// Reset values
`define MED_TX_RF_RESET 2'h0
`define SWING_RESET 3'h4
`define INT_RESET 3'h0

// Interrupt status bits
`define INT_RESTART 0
`define INT_FAR_FAULT 1
`define INT_SIG_DET 2

`endif

// file: rtl/phy_ext_page_serdes_ctrl.v
// Page-select routing and SerDes media/control registers behind an AHB-Lite slave
//
// Functional notes
// - Extended space holds fifteen registers, 16E..30E
// - Index 31 page select, 16 bits, resets zero
// - Page 0x0001 sends 16..30 to extended
// - Indices 0..15 reach standard registers except on page 0x0010
// - Writing 0x0000 returns 16..30 to main
// - Page 0x0010 sends 0..30 to GPIO
// - Media bits 15:14 transmit remote fault, reset 00
// - Media bits 13:12 report received remote fault
// - Media bit 11 enables parallel detection, reset 0
// - Media bit 10 shows signal detect
// - Bits 9,8 permit fiber link-up, reset 1
// - Bit 7 restart request, clears after read
// - Bit 6 far-end fault, clears after read
// - Control bits 9,8 enable receiver equalization
// - Swing fields 7:5, 4:2 reset to 100
`timescale 1ns/1ps
`include "phy_ext_page_consts.vh"

module phy_ext_page_serdes_ctrl (
   input wire clk, // 40 MHz bus clock
   input wire rst_n, // Synchronous reset, active low
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Byte address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write when high
   input wire [2:0] hsize, // Transfer size, word only
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   output reg [31:0] hrdata, // Read data
   output reg hreadyout, // Slave ready
   output reg hresp, // Always OKAY
   output reg ext_req, // Forwarded access strobe
   output reg [1:0] ext_space, // Forwarded space code
   output reg [4:0] ext_index, // Forwarded register index
   output reg ext_write, // Forwarded access is a write
   output reg [15:0] ext_wdata, // Forwarded write data
   input wire [15:0] ext_rdata, // Forwarded read data, valid with ext_req
   input wire [1:0] far_end_station_rf, // Remote fault bits received
   input wire sig_det, // Media signal detect level
   input wire restart_evt, // Restart request seen, level or pulse
   input wire far_fault_evt, // 100BASE-FX far-end fault seen
   output reg [1:0] tx_remote_fault, // Remote fault to transmit
   output reg parallel_detect_en, // Parallel detection enable
   output reg allow_1000x, // 1000BASE-X link-up permitted
   output reg allow_100fx, // 100BASE-FX link-up permitted
   output reg media_eq_en, // Media receiver equalization
   output reg mac_eq_en, // MAC receiver equalization
   output reg [2:0] media_swing, // Media output swing code
   output reg [2:0] mac_swing, // MAC output swing code
   output reg mac_hyst_dis, // MAC receiver hysteresis off
   output reg media_hyst_dis, // Media receiver hysteresis off
   output reg irq // Level interrupt
);

   // Bus sequencing states
   localparam ST_IDLE = 2'h0;
   localparam ST_ACCESS = 2'h1;
   localparam ST_FINISH = 2'h2;

   // Access kinds after routing
   localparam K_PAGE = 3'h0;
   localparam K_MEDIA = 3'h1;
   localparam K_CTRL = 3'h2;
   localparam K_EXT_EMPTY = 3'h3;
   localparam K_FORWARD = 3'h4;
   localparam K_LOCAL = 3'h5;

   // Captured address phase and sequencer
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [4:0] idx_reg;
   reg local_reg;
   reg wr_reg;
   reg [2:0] kind_reg;

   // Page select and self-clearing media events
   reg [15:0] page_reg;
   reg restart_reg;
   reg restart_next;
   reg far_fault_reg;
   reg far_fault_next;

   // Interrupt status and enable
   reg [2:0] int_status_reg;
   reg [2:0] int_status_next;
   reg [2:0] int_enable_reg;

   // Synchroniser chain: far fault, restart, signal detect, remote fault
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg [4:0] sync3_reg;

   // Combinational read words and routing
   reg [15:0] media_word;
   reg [15:0] ctrl_word;
   reg [15:0] rd_word;
   reg [2:0] kind_now;
   reg [1:0] space_now;

   // Handshake qualifiers and write data
   wire accept;
   wire [4:0] evt_rise;
   wire wr_now;
   wire rd_now;
   wire [15:0] wd;

   // Transfer qualifiers; hsize not checked, every register is one word
   assign accept = hsel & hready & htrans[1];
   assign wr_now = (state_reg == ST_ACCESS) & wr_reg;
   assign rd_now = (state_reg == ST_FINISH) & ~wr_reg;
   assign wd = hwdata[15:0];

   // Route an index through the page select to an access kind
   function [2:0] route_kind;
      input [4:0] idx;
      input [15:0] page;
      begin
         if (idx == `IDX_PAGE_SELECT) begin
            route_kind = K_PAGE;
         end else if (page == `PAGE_GPIO) begin
            route_kind = K_FORWARD;
         end else if (idx <= `IDX_STD_LAST) begin
            route_kind = K_FORWARD;
         end else if (page == `PAGE_EXT) begin
            if (idx == `IDX_SERDES_MEDIA) begin
               route_kind = K_MEDIA;
            end else if (idx == `IDX_SERDES_MAC) begin
               route_kind = K_CTRL;
            end else begin
               route_kind = K_EXT_EMPTY;
            end
         end else begin
            route_kind = K_FORWARD;
         end
      end
   endfunction

   // Outside space for a forwarded access
   function [1:0] route_space;
      input [4:0] idx;
      input [15:0] page;
      begin
         if (page == `PAGE_GPIO) begin
            route_space = `SPACE_GPIO;
         end else if (idx <= `IDX_STD_LAST) begin
            route_space = `SPACE_STD;
         end else begin
            route_space = `SPACE_MAIN;
         end
      end
   endfunction

   // Synchronisers for link-side inputs; stage three feeds edge detect
   // Stage one may be metastable, so only stages two and three are read
   always @(posedge clk) begin
      if (!rst_n) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
         sync3_reg <= 5'h00;
      end else begin
         sync1_reg <= {far_fault_evt, restart_evt, sig_det, far_end_station_rf};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign evt_rise = sync2_reg & ~sync3_reg;

   // Assemble readable register words
   always @* begin
      media_word = 16'h0000;
      media_word[`MED_TX_RF_HI:`MED_TX_RF_LO] = tx_remote_fault;
      media_word[`MED_LP_RF_HI:`MED_LP_RF_LO] = sync2_reg[1:0];
      media_word[`MED_PAR_DET] = parallel_detect_en;
      media_word[`MED_SIG_DET] = sync2_reg[2];
      media_word[`MED_ALLOW_1000X] = allow_1000x;
      media_word[`MED_ALLOW_100FX] = allow_100fx;
      media_word[`MED_RESTART_REQ] = restart_reg;
      media_word[`MED_FAR_FAULT] = far_fault_reg;
      ctrl_word = 16'h0000;
      ctrl_word[`CTL_MEDIA_EQ] = media_eq_en;
      ctrl_word[`CTL_MAC_EQ] = mac_eq_en;
      ctrl_word[`CTL_MEDIA_SW_HI:`CTL_MEDIA_SW_LO] = media_swing;
      ctrl_word[`CTL_MAC_SW_HI:`CTL_MAC_SW_LO] = mac_swing;
      ctrl_word[`CTL_MAC_HYST] = mac_hyst_dis;
      ctrl_word[`CTL_MEDIA_HYST] = media_hyst_dis;
   end

   // Read data mux for the finishing cycle
   always @* begin
      rd_word = 16'h0000;
      if (local_reg) begin
         if (idx_reg == `LOC_INT_STATUS) begin
            rd_word = {13'h0000, int_status_reg};
         end else if (idx_reg == `LOC_INT_ENABLE) begin
            rd_word = {13'h0000, int_enable_reg};
         end
      end else begin
         case (kind_reg)
            K_PAGE: rd_word = page_reg;
            K_MEDIA: rd_word = media_word;
            K_CTRL: rd_word = ctrl_word;
            K_FORWARD: rd_word = ext_rdata;
            default: rd_word = 16'h0000;
         endcase
      end
   end

   // Routing of the access being taken
   // Page is sampled at the address phase; a page write steers the next transfer
   always @* begin
      kind_now = route_kind(haddr[6:2], page_reg);
      space_now = route_space(haddr[6:2], page_reg);
      if (haddr[31:8] != 24'h00_0000) begin
         kind_now = K_EXT_EMPTY;
      end else if (haddr[7]) begin
         kind_now = K_LOCAL;
      end
   end

   // Bus sequencer next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               state_next = ST_ACCESS;
            end
         end
         ST_ACCESS: state_next = ST_FINISH;
         ST_FINISH: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // Self-clearing event bits: a new event beats the read clear
   // Clear lands on the edge that loads hrdata, so the read sees the set bit
   always @* begin
      restart_next = restart_reg;
      far_fault_next = far_fault_reg;
      if (rd_now && !local_reg && kind_reg == K_MEDIA) begin
         restart_next = 1'b0;
         far_fault_next = 1'b0;
      end
      if (evt_rise[3]) begin
         restart_next = 1'b1;
      end
      if (evt_rise[4]) begin
         far_fault_next = 1'b1;
      end
   end

   // Sticky interrupt status, set wins over write-one clear
   always @* begin
      int_status_next = int_status_reg;
      if (wr_now && local_reg && idx_reg == `LOC_INT_CLEAR) begin
         int_status_next = int_status_reg & ~wd[2:0];
      end
      int_status_next = int_status_next | {evt_rise[2], evt_rise[4], evt_rise[3]};
   end

   // Bus handshake, capture of the address phase and read data
   // Two wait states: access cycle writes, finish cycle loads hrdata
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         idx_reg <= 5'h00;
         local_reg <= 1'b0;
         wr_reg <= 1'b0;
         kind_reg <= K_PAGE;
         ext_req <= 1'b0;
         ext_space <= `SPACE_STD;
         ext_index <= 5'h00;
         ext_write <= 1'b0;
         ext_wdata <= 16'h0000;
      end else begin
         state_reg <= state_next;
         hresp <= 1'b0;
         ext_req <= 1'b0;
         if (state_reg == ST_IDLE && accept) begin
            hreadyout <= 1'b0;
            idx_reg <= haddr[6:2];
            local_reg <= haddr[7] & (haddr[31:8] == 24'h00_0000);
            wr_reg <= hwrite;
            kind_reg <= kind_now;
            ext_space <= space_now;
            ext_index <= haddr[6:2];
         end
         if (state_reg == ST_ACCESS && kind_reg == K_FORWARD && !local_reg) begin
            ext_req <= 1'b1;
            ext_write <= wr_reg;
            ext_wdata <= wd;
         end
         if (state_reg == ST_FINISH) begin
            hreadyout <= 1'b1;
            hrdata <= wr_reg ? 32'h0000_0000 : {16'h0000, rd_word};
         end
      end
   end

   // Page select register
   always @(posedge clk) begin
      if (!rst_n) begin
         page_reg <= `PAGE_RESET;
      end else if (wr_now && !local_reg && kind_reg == K_PAGE) begin
         page_reg <= wd;
      end
   end

   // Media register writable fields and event bits
   always @(posedge clk) begin
      if (!rst_n) begin
         tx_remote_fault <= `MED_TX_RF_RESET;
         parallel_detect_en <= 1'b0;
         allow_1000x <= 1'b1;
         allow_100fx <= 1'b1;
         restart_reg <= 1'b0;
         far_fault_reg <= 1'b0;
      end else begin
         restart_reg <= restart_next;
         far_fault_reg <= far_fault_next;
         if (wr_now && !local_reg && kind_reg == K_MEDIA) begin
            tx_remote_fault <= wd[`MED_TX_RF_HI:`MED_TX_RF_LO];
            parallel_detect_en <= wd[`MED_PAR_DET];
            allow_1000x <= wd[`MED_ALLOW_1000X];
            allow_100fx <= wd[`MED_ALLOW_100FX];
         end
      end
   end

   // MAC/media control register
   always @(posedge clk) begin
      if (!rst_n) begin
         media_eq_en <= 1'b0;
         mac_eq_en <= 1'b0;
         media_swing <= `SWING_RESET;
         mac_swing <= `SWING_RESET;
         mac_hyst_dis <= 1'b0;
         media_hyst_dis <= 1'b0;
      end else if (wr_now && !local_reg && kind_reg == K_CTRL) begin
         media_eq_en <= wd[`CTL_MEDIA_EQ];
         mac_eq_en <= wd[`CTL_MAC_EQ];
         media_swing <= wd[`CTL_MEDIA_SW_HI:`CTL_MEDIA_SW_LO];
         mac_swing <= wd[`CTL_MAC_SW_HI:`CTL_MAC_SW_LO];
         mac_hyst_dis <= wd[`CTL_MAC_HYST];
         media_hyst_dis <= wd[`CTL_MEDIA_HYST];
      end
   end

   // Interrupt status, enable and output
   // irq lags status by one cycle so it leaves a flop
   always @(posedge clk) begin
      if (!rst_n) begin
         int_status_reg <= `INT_RESET;
         int_enable_reg <= `INT_RESET;
         irq <= 1'b0;
      end else begin
         int_status_reg <= int_status_next;
         if (wr_now && local_reg && idx_reg == `LOC_INT_ENABLE) begin
            int_enable_reg <= wd[2:0];
         end
         irq <= |(int_status_reg & int_enable_reg);
      end
   end

endmodule

// file: sim/phy_ext_page_serdes_ctrl_asserts.sv
// Bus timing and control output checks for the page/SerDes register bank
`timescale 1ns/1ps
module phy_ext_page_serdes_ctrl_asserts (
   input wire clk, // Clock
   input wire rst_n, // Reset
   input wire hsel, // Select
   input wire [1:0] htrans, // Type
   input wire hready, // Ready in
   input wire [31:0] hrdata, // Read data
   input wire hreadyout, // Ready out
   input wire hresp, // Response
   input wire ext_req, // Forward strobe
   input wire [4:0] ext_index, // Forward index
   input wire [1:0] tx_remote_fault, // Fault out
   input wire allow_1000x, // Permit
   input wire allow_100fx, // Permit
   input wire [2:0] media_swing, // Swing
   input wire [2:0] mac_swing // Swing
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Accepted address phase
   wire taken = hsel && hready && htrans[1] && hreadyout;
   wire [9:0] ctl = {tx_remote_fault, allow_1000x, allow_100fx, media_swing, mac_swing};
   sequence two_waits;
      !hreadyout ##1 !hreadyout ##1 hreadyout;
   endsequence
   property reset_vals;
      $rose(rst_n) |-> ctl == 10'h0e4;
   endproperty
   a_wait_states: assert property (taken |=> two_waits)
      else $error("wait states wrong");
   a_reset_values: assert property (reset_vals)
      else $error("control reset values wrong");
   a_req_pulse: assert property (ext_req |=> !ext_req)
      else $error("forward strobe too long");
   a_req_cause: assert property (ext_req |-> $past(taken, 2))
      else $error("forward without access");
   a_req_index: assert property (ext_req |-> ext_index != 5'h1f)
      else $error("page select forwarded");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rdata_upper: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
      else $error("upper read data set");
   a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data changed idle");
   a_ctl_by_write: assert property (!$stable(ctl) |-> !$past(hreadyout))
      else $error("control changed without access");
endmodule
bind phy_ext_page_serdes_ctrl phy_ext_page_serdes_ctrl_asserts chk (.clk(clk), .rst_n(rst_n),
   .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .ext_req(ext_req), .ext_index(ext_index), .tx_remote_fault(tx_remote_fault),
   .allow_1000x(allow_1000x), .allow_100fx(allow_100fx), .media_swing(media_swing),
   .mac_swing(mac_swing));

// file: sim/ext_space_model.sv
// Outside register spaces answering forwarded accesses
`timescale 1ns/1ps
module ext_space_model (
   input wire clk, // Clock
   input wire ext_req, // Strobe
   input wire [1:0] ext_space, // Space
   input wire [4:0] ext_index, // Index
   input wire ext_write, // Write
   input wire [15:0] ext_wdata, // Write data
   output wire [15:0] ext_rdata, // Read data
   output reg [15:0] wr_data_reg = 16'h0000 // Last write
);
   reg [15:0] junk_reg = 16'h5a5a;
   // Answer only while strobed; noise otherwise
   assign ext_rdata = ext_req ? {6'h2a, ext_space, 3'h0, ext_index} : junk_reg;
   // Keep last written data
   always @(posedge clk) begin
      junk_reg <= ~junk_reg;
      if (ext_req && ext_write) begin
         wr_data_reg <= ext_wdata;
      end
   end
endmodule

// file: sim/phy_ext_page_serdes_ctrl_test.sv
// Self-checking bench for the page/SerDes register bank
`timescale 1ns/1ps
`include "phy_ext_page_consts.vh"
module phy_ext_page_serdes_ctrl_test;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0000_0000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0000_0000;
   reg [1:0] rf = 2'h0;
   reg sig_det = 1'b0;
   reg rst_evt = 1'b0;
   reg ff_evt = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, ext_req, ext_write, pd, a1g, a100, meq, ceq, mhy, chy, irq;
   wire [1:0] ext_space, tx_rf;
   wire [4:0] ext_index;
   wire [15:0] ext_wdata, ext_rdata, wr_data;
   wire [2:0] msw, csw;
   integer error_cnt = 0;
   integer comparisons = 0;
   integer req_cnt = 0;
   reg [1:0] seen_sp;
   reg [31:0] rd;
   always #12.5 clk = ~clk;
   phy_ext_page_serdes_ctrl uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .ext_req(ext_req), .ext_space(ext_space), .ext_index(ext_index),
      .ext_write(ext_write), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .far_end_station_rf(rf),
      .sig_det(sig_det), .restart_evt(rst_evt), .far_fault_evt(ff_evt), .tx_remote_fault(tx_rf),
      .parallel_detect_en(pd), .allow_1000x(a1g), .allow_100fx(a100), .media_eq_en(meq),
      .mac_eq_en(ceq), .media_swing(msw), .mac_swing(csw), .mac_hyst_dis(chy),
      .media_hyst_dis(mhy), .irq(irq));
   ext_space_model far (.clk(clk), .ext_req(ext_req), .ext_space(ext_space), .ext_index(ext_index),
      .ext_write(ext_write), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .wr_data_reg(wr_data));
   // Count forwarded accesses
   always @(posedge clk) begin
      if (ext_req === 1'b1) begin
         req_cnt <= req_cnt + 1;
         seen_sp <= ext_space;
      end
   end
   task check(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One single AHB transfer, waits for both ready edges
   task xfer(input [31:0] a, input w, input [15:0] d);
      begin
         hsel <= 1'b1;
         haddr <= a;
         hwrite <= w;
         htrans <= 2'h2;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         htrans <= 2'h0;
         hwdata <= {16'h0000, d};
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         rd = hrdata;
      end
   endtask
   task wr(input [4:0] i, input [15:0] d);
      xfer(i * 4, 1'b1, d);
   endtask
   task rc(input [4:0] i, input [15:0] e);
      begin
         xfer(i * 4, 1'b0, 16'h0000);
         check(rd, {16'h0000, e});
      end
   endtask
   // Read that must reach an outside space, or none
   task fw(input [4:0] i, input [1:0] sp, input go);
      integer c;
      begin
         c = req_cnt;
         rc(i, go ? {6'h2a, sp, 3'h0, i} : 16'h0000);
         check(req_cnt - c, go);
         if (go) check(seen_sp, sp);
      end
   endtask
   task bump(input which);
      begin
         if (which) rst_evt <= 1'b1;
         else ff_evt <= 1'b1;
         repeat (4) @(posedge clk);
         rst_evt <= 1'b0;
         ff_evt <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task t_reset;
      begin
         rc(`IDX_PAGE_SELECT, `PAGE_RESET);
         check({a1g, a100, msw, csw, tx_rf, pd, meq, ceq, mhy, chy}, 15'h7200);
         wr(`IDX_PAGE_SELECT, `PAGE_EXT);
         rc(`IDX_PAGE_SELECT, `PAGE_EXT);
         rc(`IDX_SERDES_MEDIA, 16'h0300);
         rc(`IDX_SERDES_MAC, 16'h0090);
         $display("test reset done");
      end
   endtask
   task t_route;
      begin
         fw(5'h05, `SPACE_STD, 1'b1);
         fw(5'h14, `SPACE_STD, 1'b0);
         fw(5'h1e, `SPACE_STD, 1'b0);
         wr(`IDX_PAGE_SELECT, `PAGE_GPIO);
         fw(5'h05, `SPACE_GPIO, 1'b1);
         fw(5'h1e, `SPACE_GPIO, 1'b1);
         wr(5'h03, 16'h1234);
         check(wr_data, 16'h1234);
         wr(`IDX_PAGE_SELECT, `PAGE_MAIN);
         fw(5'h10, `SPACE_MAIN, 1'b1);
         fw(5'h00, `SPACE_STD, 1'b1);
         $display("test route done");
      end
   endtask
   task t_regs;
      begin
         rf <= 2'h2;
         sig_det <= 1'b1;
         wr(`IDX_PAGE_SELECT, `PAGE_EXT);
         wr(`IDX_SERDES_MEDIA, 16'hffff);
         rc(`IDX_SERDES_MEDIA, 16'hef00);
         check({tx_rf, pd}, 3'h7);
         wr(`IDX_SERDES_MEDIA, 16'h0000);
         rc(`IDX_SERDES_MEDIA, 16'h2400);
         check({a1g, a100}, 2'h0);
         wr(`IDX_SERDES_MAC, 16'hffff);
         rc(`IDX_SERDES_MAC, 16'h03ff);
         check({meq, ceq, msw, csw, chy, mhy}, 10'h3ff);
         wr(`IDX_SERDES_MAC, 16'h00b4);
         check({msw, csw}, 6'h2d);
         $display("test regs done");
      end
   endtask
   task t_events;
      begin
         xfer(32'h0000_0088, 1'b1, 16'h0007);
         xfer(32'h0000_0084, 1'b1, 16'h0007);
         bump(1'b1);
         check(irq, 1'b1);
         rc(`IDX_SERDES_MEDIA, 16'h2480);
         rc(`IDX_SERDES_MEDIA, 16'h2400);
         bump(1'b0);
         rc(`IDX_SERDES_MEDIA, 16'h2440);
         rc(`IDX_SERDES_MEDIA, 16'h2400);
         xfer(32'h0000_0080, 1'b0, 16'h0000);
         check(rd, 32'h0000_0003);
         xfer(32'h0000_0100, 1'b0, 16'h0000);
         check(rd, 32'h0000_0000);
         xfer(32'h0000_0084, 1'b1, 16'h0000);
         repeat (2) @(posedge clk);
         check(irq, 1'b0);
         xfer(32'h0000_0084, 1'b1, 16'h0003);
         xfer(32'h0000_0088, 1'b1, 16'h0003);
         repeat (2) @(posedge clk);
         check(irq, 1'b0);
         $display("test events done");
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
         if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_route;
      t_regs;
      t_events;
      print_verdict;
   end
   // Watchdog against hangs
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt = error_cnt + 1;
      print_verdict;
   end
endmodule
